// ---- rtl/prog_seq_pkg.sv ----
/*
 Shared constants for the programmer-mode flash sequencer: command codes,
 return-code bit positions, page geometry and timing counts.
 Assumes a 200 MHz mclk; times are held in their own unit and turned into cycles here.
*/
package prog_seq_pkg;
    // ----------------------------------------------------------------
    // Clock
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 200; // Cycles per microsecond
    // ----------------------------------------------------------------
    // Command first-byte codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_STATUS = 8'h71;
    localparam logic [7:0] FILL_BYTE = 8'hFF; // Pad byte for unused page slots
    // ----------------------------------------------------------------
    // Page geometry
    // ----------------------------------------------------------------
    localparam int PAGE_BYTES = 128;
    localparam int ADDR_BITS = 17;
    localparam logic [7:0] PAGE_LO_A = 8'h00; // Legal low address bytes
    localparam logic [7:0] PAGE_LO_B = 8'h80;
    // ----------------------------------------------------------------
    // Return-code bit positions
    // ----------------------------------------------------------------
    localparam int RC_ABNORMAL = 7;
    localparam int RC_CMD_ERR = 6;
    localparam int RC_PROG_ERR = 5;
    localparam int RC_ERASE_ERR = 4;
    localparam int RC_RETRY = 1;
    localparam int RC_ADDR_ERR = 0;
    localparam logic [7:0] RC_RESET = 8'h00;
    // ----------------------------------------------------------------
    // Timing (times in own unit, counts derived)
    // ----------------------------------------------------------------
    localparam int OSC_SETTLE_MS = 10;
    localparam int SETUP_MS = 10;
    localparam int WRITE_MIN_MS = 1;
    localparam int ERASE_MIN_MS = 100;
    localparam int OSC_SETTLE_CYC = OSC_SETTLE_MS * 1000 * CLK_MHZ;
    localparam int SETUP_CYC = SETUP_MS * 1000 * CLK_MHZ;
    localparam int WRITE_CYC = WRITE_MIN_MS * 1000 * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_MIN_MS * 1000 * CLK_MHZ;
    localparam int FIFO_DEPTH = 8;
endpackage

// ---- rtl/byte_fifo.sv ----
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH]; // Storage
    logic [PW:0] wr_ptr; // Extra bit tells full from empty
    logic [PW:0] rd_ptr;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[PW-1:0]];
    // ----------------------------------------------------------------
    // Pointers and storage
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge mclk) begin
        if (push) mem[wr_ptr[PW-1:0]] <= in_data;
    end
endmodule

// ---- rtl/flash_array.sv ----
/*
 Behavioural flash array: byte reads, byte writes, whole-array erase.
 Erased state is all ones. Assumes one clock.
*/
`timescale 1ns/100ps
module flash_array
    import prog_seq_pkg::*;
#(
    parameter int ABITS = ADDR_BITS
) (
    input wire logic mclk,
    input wire logic [ABITS-1:0] rd_addr,
    output logic [7:0] rd_data,
    input wire logic wr_en,
    input wire logic [ABITS-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic erase_en
);
    initial begin
        if (ABITS < 8) $error("ABITS too small");
    end
    logic [7:0] mem [2**ABITS] = '{default: FILL_BYTE}; // Cell array, starts erased
    // ----------------------------------------------------------------
    // Cell update: erase sets every cell, write can only clear bits
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (erase_en) begin
            for (int i = 0; i < 2**ABITS; i++) begin
                mem[i] <= FILL_BYTE;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= mem[wr_addr] & wr_data; // Flash cannot raise a bit
        end
        rd_data <= mem[rd_addr];
    end
endmodule

// ---- rtl/flash_programmer_mode_sequencer.sv ----
/*
 Programmer-mode command sequencer: decodes parallel-port bus cycles, runs
 auto-program of 128-byte pages and whole-array erase, drives polling flags
 and status return code. Assumes port signals already synchronous to mclk,
 and one bus cycle per strobe low period (write taken on the falling strobe).
*/
`timescale 1ns/100ps
// Notes on behaviour
// RULE_01: program writes one full 128-byte page
// RULE_02: programmer pads short pages with FF
// RULE_03: low address byte 00/80 else flag error
// RULE_04: page address captured on second cycle
// RULE_05: no command while programming runs
// RULE_06: each page programmed once per erase
// RULE_07: erase before reprogramming an address
// RULE_08: polling flags held until next command
// RULE_09: programmer waits 1 ms before polling
// RULE_10: erase clears the whole array
// RULE_11: no command while erase runs
// RULE_12: return code survives repeated status reads
// RULE_13: return byte bits: error flags, reset zero
// RULE_14: return bits 2 and 3 undefined
// RULE_15: bit 7 low busy, high done
// RULE_16: bit 6 high normal, low abnormal
// RULE_17: polling byte 00 busy 80 fail C0 ok
// RULE_18: commands ignored during setup, then read mode
// RULE_19: programmer waits 10+10 ms after power-up
// RULE_20: programmer waits 20 us before status read
// RULE_21: codes 00 read, 40 program, 20/71 twice
// RULE_22: program takes 129 write cycles
// RULE_23: chip select/output/write strobe cycle decode
// RULE_24: write permit high for program and erase
module flash_programmer_mode_sequencer
    import prog_seq_pkg::*;
#(
    parameter int OSC_WAIT = OSC_SETTLE_CYC,
    parameter int SETUP_WAIT = SETUP_CYC,
    parameter int WRITE_WAIT = WRITE_CYC,
    parameter int ERASE_WAIT = ERASE_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic chip_sel_n,
    input wire logic out_drive_n,
    input wire logic write_strobe_n,
    input wire logic write_permit_pin,
    input wire logic [ADDR_BITS-1:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic ready,
    output logic busy
);
    initial begin
        if (OSC_WAIT < 1 || SETUP_WAIT < 1 || WRITE_WAIT < 1 || ERASE_WAIT < 1)
            $error("wait counts must be at least one");
    end
    // ----------------------------------------------------------------
    // Types and state
    // ----------------------------------------------------------------
    typedef enum {S_OSC, S_SETUP, S_IDLE, S_ERASE2, S_STAT2, S_PGADDR, S_PGDATA,
                  S_WRITE, S_ERASE} state_t;
    typedef enum {V_READ, V_POLL, V_STATUS} view_t;
    state_t state; // Sequencer state
    view_t view; // What a read returns
    logic [31:0] timer; // Shared delay counter
    logic [7:0] rc; // Status return code
    logic done_flag_line; // Polling bit 7
    logic success_flag_line; // Polling bit 6
    logic [ADDR_BITS-1:0] page_addr; // Captured page base
    logic [7:0] byte_cnt; // Data bytes taken
    logic [7:0] drain_cnt; // Bytes written into array
    logic strobe_q; // Previous strobe level
    // ----------------------------------------------------------------
    // Bus cycle decode
    // ----------------------------------------------------------------
    wire rd_cycle = !chip_sel_n && !out_drive_n && write_strobe_n; // [RULE_23]
    wire wr_cycle = !chip_sel_n && out_drive_n && !write_strobe_n; // [RULE_23]
    wire wr_take = wr_cycle && strobe_q; // First cycle of strobe low
    wire is_idle = state == S_IDLE;
    wire permit_ok = write_permit_pin; // [RULE_24]
    wire lo_ok = addr[7:0] == PAGE_LO_A || addr[7:0] == PAGE_LO_B; // [RULE_03]
    // ----------------------------------------------------------------
    // Page buffer path
    // ----------------------------------------------------------------
    logic fifo_in_ready;
    logic [7:0] fifo_out_data;
    logic fifo_out_valid;
    // Byte 0 rides on the address cycle, so that cycle pushes as well
    wire fifo_push = wr_take && (state == S_PGADDR || state == S_PGDATA); // [RULE_01]
    wire fifo_pop = fifo_out_valid && state != S_ERASE;
    wire [ADDR_BITS-1:0] wr_addr_w = page_addr + ADDR_BITS'(drain_cnt);
    logic [7:0] array_rd;
    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_data(data_in),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );
    flash_array #(.ABITS(ADDR_BITS)) u_array (
        .mclk(mclk),
        .rd_addr(addr),
        .rd_data(array_rd),
        .wr_en(fifo_pop),
        .wr_addr(wr_addr_w),
        .wr_data(fifo_out_data),
        .erase_en(state == S_ERASE && timer == 32'h1) // [RULE_10]
    );
    // ----------------------------------------------------------------
    // Read data select
    // ----------------------------------------------------------------
    wire [7:0] poll_byte = {done_flag_line, success_flag_line, 6'h00}; // [RULE_17]
    wire [7:0] next_data_out = (view == V_STATUS) ? rc :
                               (view == V_POLL) ? poll_byte : array_rd;
    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
            ready <= 1'b0;
            busy <= 1'b0;
            strobe_q <= 1'b1;
        end else begin
            data_out <= next_data_out;
            data_oe <= rd_cycle; // Released whenever chip deselected
            ready <= state != S_OSC && state != S_SETUP;
            busy <= state == S_WRITE || state == S_ERASE;
            strobe_q <= write_strobe_n || chip_sel_n;
        end
    end
    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state <= S_OSC;
            view <= V_READ;
            timer <= 32'(OSC_WAIT);
            rc <= RC_RESET; // Bits 2 and 3 never set, read 0 [RULE_13] [RULE_14]
            done_flag_line <= 1'b0;
            success_flag_line <= 1'b0;
            page_addr <= '0;
            byte_cnt <= 8'h00;
        end else begin
            case (state)
                S_OSC: begin // Commands ignored [RULE_18]
                    if (timer == 32'h1) begin
                        state <= S_SETUP;
                        timer <= 32'(SETUP_WAIT);
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                S_SETUP: begin // Commands ignored, then read mode [RULE_18]
                    if (timer == 32'h1) begin
                        state <= S_IDLE;
                        view <= V_READ;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                S_IDLE: begin
                    if (wr_take) begin
                        // Any non-status command clears old results [RULE_08] [RULE_12]
                        if (data_in != CMD_STATUS) begin
                            rc <= RC_RESET;
                            done_flag_line <= 1'b0;
                            success_flag_line <= 1'b0;
                        end
                        case (data_in) // [RULE_21]
                            CMD_READ: view <= V_READ;
                            CMD_PROG: begin
                                if (permit_ok) begin
                                    state <= S_PGADDR;
                                    view <= V_POLL;
                                end else begin
                                    rc[RC_CMD_ERR] <= 1'b1;
                                    rc[RC_ABNORMAL] <= 1'b1;
                                end
                            end
                            CMD_ERASE: state <= S_ERASE2;
                            CMD_STATUS: state <= S_STAT2;
                            default: begin
                                rc[RC_CMD_ERR] <= 1'b1;
                                rc[RC_ABNORMAL] <= 1'b1;
                            end
                        endcase
                    end
                end
                S_ERASE2: begin
                    if (wr_take) begin
                        if (data_in == CMD_ERASE && permit_ok) begin // [RULE_21] [RULE_24]
                            state <= S_ERASE;
                            view <= V_POLL;
                            timer <= 32'(ERASE_WAIT);
                        end else begin
                            state <= S_IDLE;
                            rc[RC_CMD_ERR] <= 1'b1;
                            rc[RC_ABNORMAL] <= 1'b1;
                        end
                    end
                end
                S_STAT2: begin
                    if (wr_take) begin
                        state <= S_IDLE;
                        if (data_in == CMD_STATUS) begin // [RULE_21]
                            view <= V_STATUS; // Return code kept [RULE_12]
                        end else begin
                            rc[RC_CMD_ERR] <= 1'b1;
                            rc[RC_ABNORMAL] <= 1'b1;
                        end
                    end
                end
                S_PGADDR: begin
                    if (wr_take) begin
                        // Address taken only in the second cycle [RULE_04]
                        page_addr <= {addr[ADDR_BITS-1:7], 7'h00};
                        if (!lo_ok) rc[RC_ADDR_ERR] <= 1'b1; // Write still goes ahead [RULE_03]
                        state <= S_PGDATA;
                        byte_cnt <= 8'h01;
                    end
                end
                S_PGDATA: begin
                    // Later addresses ignored; bytes stream in by count [RULE_01] [RULE_22]
                    if (wr_take) begin
                        if (byte_cnt == 8'(PAGE_BYTES - 1)) begin
                            state <= S_WRITE;
                            timer <= 32'(WRITE_WAIT);
                        end
                        byte_cnt <= byte_cnt + 8'h01;
                    end
                end
                S_WRITE: begin // Commands ignored while busy [RULE_05]
                    if (timer == 32'h1 && !fifo_out_valid) begin
                        state <= S_IDLE;
                        done_flag_line <= 1'b1; // [RULE_15]
                        success_flag_line <= !rc[RC_ADDR_ERR]; // [RULE_16]
                        if (rc[RC_ADDR_ERR]) rc[RC_ABNORMAL] <= 1'b1;
                    end else if (timer != 32'h1) begin
                        timer <= timer - 32'h1;
                    end
                end
                S_ERASE: begin // Commands ignored while busy [RULE_11]
                    if (timer == 32'h1) begin
                        state <= S_IDLE;
                        done_flag_line <= 1'b1; // [RULE_15]
                        success_flag_line <= 1'b1; // [RULE_16]
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Drain counter: bytes leave the buffer into the array in order
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!reset_n || state == S_PGADDR) begin
            drain_cnt <= 8'h00;
        end else if (fifo_pop) begin
            drain_cnt <= drain_cnt + 8'h01;
        end
    end
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_setup_ignore;
        @(posedge mclk) disable iff (!reset_n)
        (state == S_OSC || state == S_SETUP) |=> state inside {S_OSC, S_SETUP, S_IDLE};
    endproperty
    a_setup_ignore: assert property (p_setup_ignore) else $error("command taken in setup"); // [RULE_18]
    property p_poll_busy;
        @(posedge mclk) disable iff (!reset_n)
        (state == S_WRITE || state == S_ERASE) |-> !done_flag_line && !success_flag_line;
    endproperty
    a_poll_busy: assert property (p_poll_busy) else $error("busy flags wrong"); // [RULE_17]
    property p_flags_hold;
        @(posedge mclk) disable iff (!reset_n)
        (is_idle && !wr_take) |=> $stable(done_flag_line) && $stable(success_flag_line);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags changed"); // [RULE_08]
    property p_rc_keep;
        @(posedge mclk) disable iff (!reset_n)
        (state == S_STAT2 && wr_take && data_in == CMD_STATUS) |=> $stable(rc);
    endproperty
    a_rc_keep: assert property (p_rc_keep) else $error("return code lost"); // [RULE_12]
    property p_addr_err;
        @(posedge mclk) disable iff (!reset_n)
        (state == S_PGADDR && wr_take && !lo_ok) |=> rc[RC_ADDR_ERR] && state == S_PGDATA;
    endproperty
    a_addr_err: assert property (p_addr_err) else $error("address error missed"); // [RULE_03]
    property p_page_len;
        @(posedge mclk) disable iff (!reset_n)
        (state == S_PGDATA && wr_take && byte_cnt == 8'(PAGE_BYTES - 1)) |=> state == S_WRITE;
    endproperty
    a_page_len: assert property (p_page_len) else $error("page length wrong"); // [RULE_22]
    property p_done_ok;
        @(posedge mclk) disable iff (!reset_n)
        (state == S_ERASE && timer == 32'h1) |=> done_flag_line && success_flag_line;
    endproperty
    a_done_ok: assert property (p_done_ok) else $error("erase end flags wrong"); // [RULE_15]
    property p_poll_bits;
        @(posedge mclk) disable iff (!reset_n)
        (view == V_POLL) |=> data_out[5:0] == 6'h00;
    endproperty
    a_poll_bits: assert property (p_poll_bits) else $error("poll low bits set"); // [RULE_17]
    property p_busy_ignore;
        @(posedge mclk) disable iff (!reset_n)
        (state == S_ERASE && timer > 32'h1) |=> state == S_ERASE;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("erase interrupted"); // [RULE_11]
    property p_fifo_room;
        @(posedge mclk) disable iff (!reset_n)
        fifo_push |-> fifo_in_ready;
    endproperty
    a_fifo_room: assert property (p_fifo_room) else $error("page buffer overrun"); // [RULE_01]
    c_prog: cover property (@(posedge mclk) state == S_WRITE ##1 state == S_IDLE);
    c_erase: cover property (@(posedge mclk) state == S_ERASE ##1 state == S_IDLE);
    c_status: cover property (@(posedge mclk) view == V_STATUS && rd_cycle);
endmodule

// ---- bench/prog_model.sv ----
/*
 Programmer model: drives the byte-wide parallel port of the sequencer.
 Assumes pins are sampled on the rising edge of mclk.
*/
`timescale 1ns/100ps
module prog_model
    import prog_seq_pkg::*;
#(
    parameter int STS_WAIT = 4000
) (
    input wire logic mclk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic chip_sel_n,
    output logic out_drive_n,
    output logic write_strobe_n,
    output logic write_permit_pin,
    output logic [ADDR_BITS-1:0] addr,
    output logic [7:0] data_in
);
    // ----------------------------------------
    // Pins idle, strobes high
    // ----------------------------------------
    initial begin
        {chip_sel_n, out_drive_n, write_strobe_n, write_permit_pin} = 4'hE;
        addr = 17'h00000;
        data_in = 8'h00;
    end
    // One write strobe; released bus shows the inverse, not the last byte
    task automatic wr(input logic [16:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        addr = a;
        data_in = d;
        {chip_sel_n, write_strobe_n} = 2'h0;
        @(posedge mclk);
        #1;
        {chip_sel_n, write_strobe_n} = 2'h3;
        data_in = ~d;
    endtask
    // Read cycle; answer settles two cycles after the controls
    task automatic rd(input logic [16:0] a, output logic [7:0] d, output logic oe);
        @(posedge mclk);
        #1;
        addr = a;
        {chip_sel_n, out_drive_n} = 2'h0;
        repeat (3) @(posedge mclk);
        #1;
        d = data_out;
        oe = data_oe;
        {chip_sel_n, out_drive_n} = 2'h3;
    endtask
    // Page program; address b re-sent unchanged with the command and every byte
    task automatic prog(input logic [16:0] b, input logic permit, input int nreal);
        write_permit_pin = permit;
        wr(b, CMD_PROG);
        for (int k = 0; k < PAGE_BYTES && permit; k++) begin
            wr(b, (k < nreal) ? (8'hA5 ^ 8'(k)) : FILL_BYTE);
        end
        write_permit_pin = 1'b0;
    endtask
    task automatic erase();
        write_permit_pin = 1'b1;
        wr(17'h00000, CMD_ERASE);
        wr(17'h00000, CMD_ERASE);
        write_permit_pin = 1'b0;
    endtask
    // Status command pair, then the settle wait before reading
    task automatic status();
        wr(17'h00000, CMD_STATUS);
        wr(17'h00000, CMD_STATUS);
        repeat (STS_WAIT) @(posedge mclk);
    endtask
endmodule

// ---- bench/tb_top.sv ----
/*
 Top bench: scaled setup and run times, row table of commands, then hand tests.
 Assumes the programmer model owns every port pin of the sequencer.
*/
`timescale 1ns/100ps
module tb_top;
    import prog_seq_pkg::*;
    // ----------------------------------------
    // Signals and row table
    // ----------------------------------------
    logic mclk;
    logic reset_n;
    logic chip_sel_n, out_drive_n, write_strobe_n, write_permit_pin;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0] data_in, data_out, rd_v;
    logic data_oe, ready, busy, oe_v;
    int err_total = 0;
    int compares = 0;
    int probe[3] = '{3, 4, 127};
    // Op: 0 erase, 1 program, 2 unknown code; poll and return code expected
    typedef struct packed {logic [1:0] op; logic [16:0] b; logic pm; logic [7:0] poll;
        logic [7:0] rc;} case_t;
    case_t r;
    // Erase first, then each page programmed once only
    case_t rows[6] = '{{2'h0, 17'h00000, 1'b1, 8'hC0, 8'h00},
        {2'h1, 17'h00000, 1'b1, 8'hC0, 8'h00}, {2'h1, 17'h00080, 1'b1, 8'hC0, 8'h00},
        {2'h1, 17'h00105, 1'b1, 8'h80, 8'h81}, {2'h2, 17'h00000, 1'b0, 8'h00, 8'hC0},
        {2'h1, 17'h00200, 1'b0, 8'h00, 8'hC0}};
    // Short waits keep the run small
    flash_programmer_mode_sequencer #(.OSC_WAIT(20), .SETUP_WAIT(20), .WRITE_WAIT(200),
        .ERASE_WAIT(50)) flash_programmer_mode_sequencer_i (.mclk(mclk), .reset_n(reset_n),
        .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n), .write_strobe_n(write_strobe_n),
        .write_permit_pin(write_permit_pin), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .ready(ready), .busy(busy));
    prog_model #(.STS_WAIT(4000)) prog_model_i (.mclk(mclk), .data_out(data_out),
        .data_oe(data_oe), .chip_sel_n(chip_sel_n), .out_drive_n(out_drive_n),
        .write_strobe_n(write_strobe_n), .write_permit_pin(write_permit_pin),
        .addr(addr), .data_in(data_in));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_b(input logic [16:0] b, input int k);
        return (b == 17'h00000 && k >= 4) ? FILL_BYTE : (8'hA5 ^ 8'(k));
    endfunction
    // Waits out a run; bounded so a stuck busy cannot hang
    task automatic wait_idle(input logic want);
        logic seen;
        seen = 1'b0;
        for (int n = 0; n < 600; n++) begin
            @(posedge mclk);
            #1;
            seen = seen | busy;
            if (seen && busy === 1'b0) break;
        end
        chk({7'h00, seen}, {7'h00, want});
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog, well past the expected run length
    initial begin
        repeat (80000) @(posedge mclk);
        err_total++;
        print_verdict();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        repeat (20) @(posedge mclk);
        #1;
        chk({5'h00, ready, busy, data_oe}, 8'h00);
        reset_n = 1'b1;
        prog_model_i.erase(); // Ignored: still in setup
        wait_idle(1'b0);
        for (int n = 0; n < 200 && ready !== 1'b1; n++) @(posedge mclk);
        prog_model_i.rd(17'h00010, rd_v, oe_v);
        chk(rd_v, 8'hFF);
        $display("Setup test done");
        foreach (rows[i]) begin
            r = rows[i];
            case (r.op)
                2'h0: prog_model_i.erase();
                2'h1: prog_model_i.prog(r.b, r.pm, (r.b == 17'h00000) ? 4 : PAGE_BYTES);
                default: prog_model_i.wr(17'h00000, 8'h55);
            endcase
            wait_idle(r.pm);
            repeat (r.pm ? 2 : 0) begin
                prog_model_i.rd(r.b, rd_v, oe_v);
                chk(rd_v, r.poll);
                chk({7'h00, oe_v}, 8'h01);
            end
            prog_model_i.status();
            prog_model_i.rd(17'h00000, rd_v, oe_v);
            chk(rd_v, r.rc);
            if (r.op == 2'h1 && r.pm) begin
                prog_model_i.wr(17'h00000, CMD_READ);
                foreach (probe[j]) begin
                    prog_model_i.rd({r.b[16:7], 7'h00} + 17'(probe[j]), rd_v, oe_v);
                    chk(rd_v, exp_b(r.b, probe[j]));
                end
            end
            $display("Row %0d done", i);
        end
        prog_model_i.status();
        prog_model_i.rd(17'h00000, rd_v, oe_v);
        chk(rd_v, 8'hC0);
        prog_model_i.erase();
        wait_idle(1'b1);
        prog_model_i.wr(17'h00000, CMD_READ);
        prog_model_i.rd(17'h00003, rd_v, oe_v);
        chk(rd_v, 8'hFF);
        prog_model_i.rd(17'h00185, rd_v, oe_v);
        chk(rd_v, 8'hFF);
        $display("Erase and persistence test done");
        reset_n = 1'b0; // Second reset in mid-run
        repeat (2) @(posedge mclk);
        #1;
        chk({5'h00, ready, busy, data_oe}, 8'h00);
        reset_n = 1'b1;
        repeat (60) @(posedge mclk);
        #1;
        chk({7'h00, ready}, 8'h01);
        prog_model_i.rd(17'h00003, rd_v, oe_v);
        chk(rd_v, 8'hFF);
        $display("Mid-run reset test done");
        print_verdict();
    end
endmodule
